// >>> light_sensor_integration_time_cfg.sv
// Light sensor end: opcode decode, integration time register, conversion timer
// Notes on behaviour
// - Low four time bits fixed at 1100
// - Time register resets to 300
// - Prefix 010 loads time bits 9..5
// - Prefix 011 loads bit 4, rest ignored
// - Counts scale with time register value
// - Every mode's time scales with register
// - Doubled register doubles high-resolution conversion time
// - Host keeps register within 140..1020
// - Host scales counts to lux itself
// - Host changes time only in power down
// - Any measurement opcode uses new time
// - Low reset pin clears registers asynchronously
// - Decode power down, on, measurement opcodes
// - One opcode per transaction
// - Reset held low forces power down
`timescale 1ns/1ps
module light_sensor_integration_time_cfg #(
  parameter int HRES_BASE = light_cfg_pkg::HRES_CYCLES,
  parameter int LRES_BASE = light_cfg_pkg::LRES_CYCLES
) (
  // Clock
  input  wire logic        pclk,
  input  wire logic        clk_en,
  // Link
  light_cmd_if.sensor      link,
  // Light front end, counts per unit time
  input  wire logic [5:0]  light_level
);
  // What a received opcode asks of the sensor
  typedef enum logic [2:0] {
    OPC_NONE = 3'b000,
    OPC_DOWN = 3'b001,
    OPC_ON   = 3'b011,
    OPC_HRES = 3'b010,
    OPC_AUTO = 3'b110,
    OPC_LRES = 3'b111,
    OPC_HIGH = 3'b101,
    OPC_BIT4 = 3'b100
  } op_class_t;

  // Sort an opcode by its prefix or its full code
  function automatic op_class_t classify(input logic [7:0] op);
    if (op[7:5] == light_cfg_pkg::PFX_HIGH)
      classify = OPC_HIGH;
    else if (op[7:5] == light_cfg_pkg::PFX_BIT4)
      classify = OPC_BIT4;
    else if (op == light_cfg_pkg::OP_POWER_DOWN)
      classify = OPC_DOWN;
    else if (op == light_cfg_pkg::OP_POWER_ON)
      classify = OPC_ON;
    else if (op == light_cfg_pkg::OP_HRES_A || op == light_cfg_pkg::OP_HRES_B)
      classify = OPC_HRES;
    else if (op == light_cfg_pkg::OP_AUTO_A || op == light_cfg_pkg::OP_AUTO_B)
      classify = OPC_AUTO;
    else if (op == light_cfg_pkg::OP_LRES_A || op == light_cfg_pkg::OP_LRES_B ||
             op == light_cfg_pkg::OP_LRES_C || op == light_cfg_pkg::OP_LRES_D)
      classify = OPC_LRES;
    else
      classify = OPC_NONE;
  endfunction : classify

  // Reset release
  logic        rst_meta;
  logic        rst_n_s;

  // Time register, mode and conversion state
  logic [5:0]  time_high_reg;
  logic        time_bit4_reg;
  logic [9:0]  time_value;
  light_cfg_pkg::mode_t mode_reg;
  logic        hres_reg;
  logic        auto_reg;
  logic [31:0] tick_reg;
  logic [31:0] acc_reg;
  logic [15:0] result_reg;
  logic        result_valid_reg;
  logic [31:0] period;
  logic        take;

  // Decoded opcode and the strobes taken from it
  op_class_t   op_class;
  logic        load_ok;
  logic        measuring;
  logic        window_end;

  assign time_value = {time_high_reg[4:0], time_bit4_reg,
                       light_cfg_pkg::TIME_LOW_FIXED};
  assign take       = link.op_valid & clk_en;
  // Opcodes count only once the reset release is synchronised
  assign load_ok    = take & rst_n_s;
  assign op_class   = classify(link.op_code);
  assign measuring  = (mode_reg == light_cfg_pkg::MODE_MEAS);

  // Last cycle of the conversion window
  assign window_end = (tick_reg + 32'h1 >= period);

  // Scale base period by time/300
  function automatic logic [31:0] scaled(input int base, input logic [9:0] t);
    logic [47:0] p;
    p = 48'(base) * 48'(t);
    scaled = 32'(p / 48'd300);
  endfunction : scaled

  // Auto mode reports on a coarser scale than the fixed modes
  function automatic logic [15:0] pick_result(input logic [31:0] acc,
                                               input logic        coarse);
    if (coarse)
      pick_result = acc[31:16];
    else
      pick_result = acc[28:13];
  endfunction : pick_result

  assign period = scaled(hres_reg ? HRES_BASE : LRES_BASE, time_value);

  // Reset pin is the asynchronous reset itself
  always_ff @(posedge pclk or negedge link.reset_n) begin
    if (!link.reset_n) begin
      rst_meta <= 1'b0;
      rst_n_s  <= 1'b0;
    end else if (clk_en) begin
      rst_meta <= 1'b1;
      rst_n_s  <= rst_meta;
    end
  end

  // Upper time bits; bit 4 and the fixed nibble stay put
  always_ff @(posedge pclk or negedge link.reset_n) begin
    if (!link.reset_n) begin
      time_high_reg <= {1'b0, light_cfg_pkg::TIME_RESET[9:5]};
    end else if (load_ok && op_class == OPC_HIGH) begin
      time_high_reg <= {1'b0, link.op_code[4:0]};
    end
  end

  // Bit 4 alone; the low opcode nibble is ignored
  always_ff @(posedge pclk or negedge link.reset_n) begin
    if (!link.reset_n) begin
      time_bit4_reg <= light_cfg_pkg::TIME_RESET[4];
    end else if (load_ok && op_class == OPC_BIT4) begin
      time_bit4_reg <= link.op_code[4];
    end
  end

  // Mode decode
  always_ff @(posedge pclk or negedge link.reset_n) begin
    if (!link.reset_n) begin
      // Power down is also the reset state
      mode_reg <= light_cfg_pkg::MODE_DOWN;
      hres_reg <= 1'b1;
      auto_reg <= 1'b0;
    end else if (load_ok) begin
      case (op_class)
        OPC_DOWN: mode_reg <= light_cfg_pkg::MODE_DOWN;
        OPC_ON:   mode_reg <= light_cfg_pkg::MODE_IDLE;
        OPC_HRES: begin
          mode_reg <= light_cfg_pkg::MODE_MEAS;
          hres_reg <= 1'b1;
          auto_reg <= 1'b0;
        end
        OPC_AUTO: begin
          mode_reg <= light_cfg_pkg::MODE_MEAS;
          hres_reg <= 1'b1;
          auto_reg <= 1'b1;
        end
        OPC_LRES: begin
          mode_reg <= light_cfg_pkg::MODE_MEAS;
          hres_reg <= 1'b0;
          auto_reg <= 1'b0;
        end
        // Time loads and undefined opcodes leave the mode as it is
        default: mode_reg <= mode_reg;
      endcase
    end
  end

  // Integration: counts grow with the time spent integrating
  always_ff @(posedge pclk or negedge link.reset_n) begin
    if (!link.reset_n) begin
      tick_reg         <= 32'h0;
      acc_reg          <= 32'h0;
      result_reg       <= 16'h0;
      result_valid_reg <= 1'b0;
    end else if (clk_en) begin
      result_valid_reg <= 1'b0;
      // A new opcode or a stopped mode restarts the window
      if (take || !measuring) begin
        tick_reg <= 32'h0;
        acc_reg  <= 32'h0;
      end else if (window_end) begin
        tick_reg         <= 32'h0;
        acc_reg          <= 32'h0;
        result_reg       <= pick_result(acc_reg, auto_reg);
        result_valid_reg <= 1'b1;
      end else begin
        tick_reg <= tick_reg + 32'h1;
        acc_reg  <= acc_reg + {26'h0, light_level};
      end
    end
  end

  // Link outputs, each straight from a flop
  assign link.op_ready     = rst_n_s;
  assign link.result       = result_reg;
  assign link.result_valid = result_valid_reg;
endmodule : light_sensor_integration_time_cfg

// >>> light_cfg_pkg.sv
// Shared constants for the light sensor integration time logic
package light_cfg_pkg;
  localparam logic [9:0] TIME_RESET     = 10'h12C;
  localparam logic [3:0] TIME_LOW_FIXED = 4'hC;
  localparam logic [2:0] PFX_HIGH       = 3'h2;
  localparam logic [2:0] PFX_BIT4       = 3'h3;
  localparam logic [7:0] OP_POWER_DOWN  = 8'h00;
  localparam logic [7:0] OP_POWER_ON    = 8'h01;
  localparam logic [7:0] OP_AUTO_A      = 8'h10;
  localparam logic [7:0] OP_AUTO_B      = 8'h20;
  localparam logic [7:0] OP_HRES_A      = 8'h12;
  localparam logic [7:0] OP_HRES_B      = 8'h22;
  localparam logic [7:0] OP_LRES_A      = 8'h13;
  localparam logic [7:0] OP_LRES_B      = 8'h16;
  localparam logic [7:0] OP_LRES_C      = 8'h23;
  localparam logic [7:0] OP_LRES_D      = 8'h26;
  localparam int         CLK_MHZ        = 200;
  localparam int         HRES_TIME_US   = 120000;
  localparam int         LRES_TIME_US   = 16000;
  localparam int         RESET_HOLD_US  = 1;
  localparam int         HRES_CYCLES    = HRES_TIME_US * CLK_MHZ;
  localparam int         LRES_CYCLES    = LRES_TIME_US * CLK_MHZ;
  localparam int         RESET_CYCLES   = RESET_HOLD_US * CLK_MHZ;
  localparam logic [9:0] TIME_MIN       = 10'h08C;
  localparam logic [9:0] TIME_MAX       = 10'h3FC;
  localparam logic [5:0] OFF_CMD        = 6'h00;
  localparam logic [5:0] OFF_STATUS     = 6'h04;
  localparam logic [5:0] OFF_RESULT     = 6'h08;
  localparam logic [5:0] OFF_RESET      = 6'h0C;
  typedef enum logic [1:0] {
    MODE_DOWN = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_MEAS = 2'b11
  } mode_t;
endpackage : light_cfg_pkg

// >>> light_cmd_if.sv
// Opcode link between the host controller and the light sensor
`timescale 1ns/1ps
interface light_cmd_if;
  logic       op_valid;
  logic [7:0] op_code;
  logic       op_ready;
  logic       reset_n;
  logic [15:0] result;
  logic       result_valid;
  modport sensor (input op_valid, op_code, reset_n, output op_ready, result, result_valid);
  modport host   (output op_valid, op_code, reset_n, input op_ready, result, result_valid);
endinterface : light_cmd_if

// >>> light_host_ctrl.sv
// Host end: APB registers that issue opcodes and hold the sensor reset
`timescale 1ns/1ps
module light_host_ctrl (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [5:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Link
  light_cmd_if.host        link
);
  logic        acc;
  logic        op_valid_reg;
  logic [7:0]  op_code_reg;
  logic        rst_hold_reg;
  logic [15:0] rst_cnt_reg;
  logic [15:0] result_reg;
  logic        fresh_reg;

  assign acc = psel & penable & clk_en;

  // One opcode per write, one cycle each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_valid_reg <= 1'b0;
      op_code_reg  <= 8'h00;
    end else if (clk_en) begin
      op_valid_reg <= acc && pwrite && paddr == light_cfg_pkg::OFF_CMD && link.op_ready;
      if (acc && pwrite && paddr == light_cfg_pkg::OFF_CMD)
        op_code_reg <= pwdata[7:0];
    end
  end

  // Hold sensor reset low at least 1 us
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_hold_reg <= 1'b0;
      rst_cnt_reg  <= 16'h0;
    end else if (clk_en) begin
      if (acc && pwrite && paddr == light_cfg_pkg::OFF_RESET) begin
        rst_hold_reg <= 1'b0;
        rst_cnt_reg  <= 16'h0;
      end else if (rst_cnt_reg < 16'(light_cfg_pkg::RESET_CYCLES)) begin
        rst_cnt_reg <= rst_cnt_reg + 16'h1;
      end else begin
        rst_hold_reg <= 1'b1;
      end
    end
  end

  // Result capture; new data wins over the read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= 16'h0;
      fresh_reg  <= 1'b0;
    end else if (clk_en) begin
      if (link.result_valid) begin
        result_reg <= link.result;
        fresh_reg  <= 1'b1;
      end else if (acc && !pwrite && paddr == light_cfg_pkg::OFF_RESULT) begin
        fresh_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && !penable) begin
        if (paddr == light_cfg_pkg::OFF_CMD)
          prdata <= {24'h0, op_code_reg};
        else if (paddr == light_cfg_pkg::OFF_STATUS)
          prdata <= {29'h0, fresh_reg, rst_hold_reg, link.op_ready};
        else if (paddr == light_cfg_pkg::OFF_RESULT)
          prdata <= {16'h0, result_reg};
        else if (paddr == light_cfg_pkg::OFF_RESET)
          prdata <= 32'h0;
        else
          pslverr <= 1'b1;
      end
    end
  end

  assign link.op_valid = op_valid_reg;
  assign link.op_code  = op_code_reg;
  assign link.reset_n  = rst_hold_reg;
endmodule : light_host_ctrl

// >>> light_link_properties.sv
// Assertions on the opcode link between host and sensor
`timescale 1ns/1ps
module light_link_properties #(
  parameter int HRES_BASE = 3000,
  parameter int LRES_BASE = 400
) (
  // Clock and resets
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        reset_n,
  // Link
  input wire logic        op_valid,
  input wire logic [7:0]  op_code,
  input wire logic        op_ready,
  input wire logic [15:0] result,
  input wire logic        result_valid
);
  logic [4:0] hi_reg;
  logic       b4_reg;
  logic [1:0] run_reg;
  int         cnt_reg;
  int         lim;
  default clocking @(posedge pclk); endclocking
  default disable iff (!reset_n);
  // Shadow time register, low nibble fixed
  always_ff @(posedge pclk or negedge reset_n) begin
    if (!reset_n) {hi_reg, b4_reg} <= 6'h12;
    else if (op_valid && op_code[7:5] == 3'h2) hi_reg <= op_code[4:0];
    else if (op_valid && op_code[7:5] == 3'h3) b4_reg <= op_code[4];
  end
  always_ff @(posedge pclk or negedge reset_n) begin
    if (!reset_n) run_reg <= 2'h0;
    else if (op_valid) begin
      case (op_code)
        8'h10, 8'h20, 8'h12, 8'h22: run_reg <= 2'h1;
        8'h13, 8'h16, 8'h23, 8'h26: run_reg <= 2'h2;
        8'h00, 8'h01: run_reg <= 2'h0;
        default: run_reg <= run_reg;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge reset_n) begin
    if (!reset_n || op_valid || result_valid) cnt_reg <= 0;
    else cnt_reg <= cnt_reg + 1;
  end
  assign lim = (run_reg == 2'h1 ? HRES_BASE : LRES_BASE) * int'({hi_reg, b4_reg, 4'hC}) / 300;
  chk_reset_ready: assert property (disable iff (!presetn) !reset_n |-> !op_ready)
    else $error("ready during reset");
  chk_ready_delay: assert property (disable iff (!presetn)
    $rose(reset_n) |-> !op_ready ##[1:3] op_ready)
    else $error("ready late");
  chk_op_pulse: assert property (op_valid |=> !op_valid)
    else $error("opcode not a pulse");
  chk_op_ready: assert property (op_valid |-> op_ready)
    else $error("opcode while not ready");
  chk_res_pulse: assert property (result_valid |=> !result_valid)
    else $error("result not a pulse");
  chk_period_match: assert property (
    result_valid && run_reg != 2'h0 |-> cnt_reg >= lim - 3 && cnt_reg <= lim + 3)
    else $error("conversion period off");
  chk_period_bound: assert property (run_reg != 2'h0 |-> cnt_reg <= lim + 3)
    else $error("conversion overdue");
  chk_down_quiet: assert property (
    run_reg == 2'h0 && $past(run_reg) == 2'h0 |-> !result_valid)
    else $error("result while stopped");
endmodule : light_link_properties

// >>> light_sensor_integration_time_cfg_tb.sv
// Self-checking bench for host controller and sensor on the opcode link
`timescale 1ns/1ps
module light_sensor_integration_time_cfg_tb;
  localparam int HB = 3000;
  localparam int LB = 400;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [5:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] res0, got;
  logic [23:0] tbl [10] = '{24'h527510, 24'h527520, 24'h527512, 24'h527522, 24'h527513,
                           24'h527516, 24'h527523, 24'h527526, 24'h5F7013, 24'h446F16};
  int          fail_count, total_checks, n, t;
  light_cmd_if link ();
  light_host_ctrl u_light_host_ctrl (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  light_sensor_integration_time_cfg #(.HRES_BASE(HB), .LRES_BASE(LB))
    u_light_sensor_integration_time_cfg (.pclk(pclk), .clk_en(1'b1), .link(link),
    .light_level(6'h3F));
  light_link_properties #(.HRES_BASE(HB), .LRES_BASE(LB)) u_light_link_properties (
    .pclk(pclk), .presetn(presetn), .reset_n(link.reset_n), .op_valid(link.op_valid),
    .op_code(link.op_code), .op_ready(link.op_ready), .result(link.result),
    .result_valid(link.result_valid));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic [5:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_ready;
    n = 0;
    do begin
      apb(6'h04, 1'b0, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 200);
    chk("status", 32'h3, rd);
  endtask : wait_ready
  task automatic meas(input logic [7:0] op, input int e);
    apb(6'h00, 1'b1, {24'h0, op});
    n = 0;
    while (link.result_valid !== 1'b1 && n < 2 * e + 50) begin
      @(negedge pclk);
      n++;
    end
    got = link.result;
    chk("period", 1'b1, n >= e - 4 && n <= e + 4);
    @(posedge pclk);
  endtask : meas
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 6'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wait_ready();
    apb(6'h10, 1'b0, 32'h0);
    chk("unmapped_err", 1'b1, err);
    meas(8'h12, HB);
    res0 = got;
    apb(6'h04, 1'b0, 32'h0);
    chk("fresh", 1'b1, rd[2]);
    apb(6'h08, 1'b0, 32'h0);
    chk("result", {16'h0, res0}, rd);
    apb(6'h00, 1'b0, 32'h0);
    chk("cmd_readback", 32'h12, rd);
    $display("test default done");
    for (int i = 0; i < 10; i++) begin
      apb(6'h00, 1'b1, 32'h0);
      apb(6'h00, 1'b1, {24'h0, tbl[i][23:16]});
      apb(6'h00, 1'b1, {24'h0, tbl[i][15:8]});
      t = int'({tbl[i][20:16], tbl[i][12], 4'hC});
      meas(tbl[i][7:0], ((tbl[i][2] | tbl[i][0]) ? LB : HB) * t / 300);
      if (i == 2) chk("scaled_count", 1'b1,
                      got * 300 <= res0 * t + 2 * t && got * 300 + 2 * t >= res0 * t);
    end
    $display("test time table done");
    apb(6'h00, 1'b1, 32'h0);
    apb(6'h08, 1'b0, 32'h0);
    apb(6'h0C, 1'b1, 32'h1);
    apb(6'h04, 1'b0, 32'h0);
    chk("ready_in_reset", 1'b0, rd[0]);
    wait_ready();
    meas(8'h13, LB);
    $display("test sensor reset done");
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge pclk);
    fail_count++;
    complete_run();
  end
endmodule : light_sensor_integration_time_cfg_tb
